// [core/cmicg_core.v]
// Purpose: control wrapper of a can controller: mode, interrupt routing, clock gate
// Assumes: aclk 200 MHz, synchronous active-low aresetn, axi4-lite slave
// Notes: registers are ctrl, mode request, status, group flags/clear, class b flags,
// Notes: and an own sticky event status with a mask driving irq
`timescale 1ns/1ps
`include "cmicg_defs.vh"

module cmicg_core #(
	parameter N_SRC = 4
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [4:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output wire             s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output wire             s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [4:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output wire             s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	input  wire [N_SRC-1:0] can_irq_src,
	input  wire             can_mode_ack,
	output reg  [1:0]       can_mode,
	output wire             can_clk_en,
	output wire [N_SRC-1:0] group_edge_irq_req,
	output wire             soft_cfg_irq_b_req,
	output wire             dma_trigger,
	output wire             irq
);

	// register state
	reg              module_stop_reg;
	reg  [1:0]       mode_req_reg;
	reg  [N_SRC-1:0] src_prev_reg;
	reg  [N_SRC-1:0] group_edge_irq_status_flag_reg;
	reg  [N_SRC-1:0] soft_cfg_irq_b_status_flag_reg;
	reg  [1:0]       irq_stat_reg;
	reg  [1:0]       irq_mask_reg;
	reg  [4:0]       awaddr_reg;
	reg  [31:0]      wdata_reg;
	reg  [3:0]       wstrb_reg;
	reg              aw_held_reg;
	reg              w_held_reg;

	wire [N_SRC-1:0] src_rise;
	wire             wr_fire;
	wire             rd_fire;
	wire [4:0]       wr_addr;
	wire [31:0]      wr_data;
	wire [3:0]       wr_strb;
	wire [N_SRC-1:0] grp_clr;
	wire             stat_rd;
	wire [1:0]       evt;
	wire             mode_take;
	wire             wr_ok;
	wire             ctrl_wr;
	wire             mode_wr;
	wire             mask_wr;
	wire             clr_wr;
	reg  [31:0]      rd_data;
	reg              rd_err;

	// true when the byte offset is a mapped register
	function mapped;
		input [4:0] a;
		begin
			mapped = (a[1:0] == 2'h0);
		end
	endfunction

	// one accepted write of byte zero to the given offset
	function wr_sel;
		input       fire;
		input       strb0;
		input [4:0] a;
		input [4:0] ofs;
		begin
			wr_sel = fire && strb0 && (a == ofs);
		end
	endfunction

	// rising edges of the controller's request lines
	assign src_rise = can_irq_src & ~src_prev_reg;

	// grouped edge line carries each newly detected edge, class b a level of any source
	assign group_edge_irq_req = src_rise;
	assign soft_cfg_irq_b_req = |can_irq_src;
	// can sources have no path into dtc or dma activation
	assign dma_trigger = 1'b0;

	// controller clock only while module stop is released
	assign can_clk_en = ~module_stop_reg;

	// axi write path
	// each half refused while it is held or while the response waits
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

	// a held half stands in for the live bus
	assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
	assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

	// both halves present and no response outstanding
	assign wr_fire = ~s_axi_bvalid & (aw_held_reg | s_axi_awvalid)
		& (w_held_reg | s_axi_wvalid);

	// response code: aligned and inside the map
	assign wr_ok = mapped(wr_addr) && (wr_addr <= `CMICG_OFS_IRQ_MASK);

	// per-register write strobes, all fields sit in byte zero
	assign ctrl_wr = wr_sel(wr_fire, wr_strb[0], wr_addr, `CMICG_OFS_CTRL);
	assign mode_wr = wr_sel(wr_fire, wr_strb[0], wr_addr, `CMICG_OFS_MODE_REQ);
	assign mask_wr = wr_sel(wr_fire, wr_strb[0], wr_addr, `CMICG_OFS_IRQ_MASK);
	assign clr_wr  = wr_sel(wr_fire, wr_strb[0], wr_addr, `CMICG_OFS_GRP_CLR);

	// address and data taken in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= 5'h00;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CMICG_RESP_OKAY;
		end else begin
			if (wr_fire) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `CMICG_RESP_OKAY : `CMICG_RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_reg <= 1'b1;
					awaddr_reg  <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_reg <= 1'b1;
					wdata_reg  <= s_axi_wdata;
					wstrb_reg  <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// one written to a group clear bit acknowledges that source
	assign grp_clr = clr_wr ? wr_data[N_SRC-1:0] : {N_SRC{1'b0}};

	// module stop: set by reset, released only by software
	always @(posedge aclk) begin
		if (!aresetn) begin
			module_stop_reg <= `CMICG_CTRL_RST;
		end else if (ctrl_wr) begin
			module_stop_reg <= wr_data[0];
		end
	end

	// requested mode: sleep after reset, writes ignored while the clock is stopped
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_req_reg <= `CMICG_MODE_SLEEP;
		end else if (mode_wr && !module_stop_reg) begin
			mode_req_reg <= wr_data[1:0];
		end
	end

	// interrupt mask, same layout as the event status
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_reg <= `CMICG_MASK_RST;
		end else if (mask_wr) begin
			irq_mask_reg <= wr_data[1:0];
		end
	end

	// a mode is accepted only while the controller clock runs
	assign mode_take = can_mode_ack & ~module_stop_reg;

	// controller stays in sleep after reset until a new mode is acknowledged
	always @(posedge aclk) begin
		if (!aresetn) begin
			can_mode <= `CMICG_MODE_SLEEP;
		end else if (mode_take) begin
			can_mode <= mode_req_reg;
		end
	end

	// previous level of each request line, idle low after reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			src_prev_reg <= {N_SRC{1'b0}};
		end else begin
			src_prev_reg <= can_irq_src;
		end
	end

	// group flags: set on a rising edge, cleared by a one; set beats clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			group_edge_irq_status_flag_reg <= {N_SRC{1'b0}};
		end else begin
			group_edge_irq_status_flag_reg <=
				(group_edge_irq_status_flag_reg & ~grp_clr) | src_rise;
		end
	end

	// class b flags: never cleared by hardware; only record, never gate requests
	always @(posedge aclk) begin
		if (!aresetn) begin
			soft_cfg_irq_b_status_flag_reg <= {N_SRC{1'b0}};
		end else begin
			soft_cfg_irq_b_status_flag_reg <=
				soft_cfg_irq_b_status_flag_reg | can_irq_src;
		end
	end

	// own event status: bit0 any group edge, bit1 accepted mode acknowledge; read clears
	assign evt     = {mode_take, |src_rise};
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign stat_rd = rd_fire && s_axi_araddr == `CMICG_OFS_IRQ_STAT;

	// a read clears the status, an event in the same cycle still sets it
	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= (stat_rd ? 2'h0 : irq_stat_reg) | evt;
		end
	end

	// level interrupt while any unmasked event is pending
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// axi read path
	assign s_axi_arready = ~s_axi_rvalid;

	// read data selection; unmapped offsets read zero with an error response
	always @* begin
		rd_data = 32'h00000000;
		rd_err  = 1'b0;
		case (s_axi_araddr)
			`CMICG_OFS_CTRL: begin
				rd_data[0] = module_stop_reg;
			end
			`CMICG_OFS_MODE_REQ: begin
				rd_data[1:0] = mode_req_reg;
			end
			`CMICG_OFS_STATUS: begin
				rd_data[1:0] = can_mode;
			end
			`CMICG_OFS_GRP_FLAG: begin
				rd_data[N_SRC-1:0] = group_edge_irq_status_flag_reg;
			end
			`CMICG_OFS_GRP_CLR: begin
				rd_data = 32'h00000000;
			end
			`CMICG_OFS_SCI_FLAG: begin
				rd_data[N_SRC-1:0] = soft_cfg_irq_b_status_flag_reg;
			end
			`CMICG_OFS_IRQ_STAT: begin
				rd_data[1:0] = irq_stat_reg;
			end
			`CMICG_OFS_IRQ_MASK: begin
				rd_data[1:0] = irq_mask_reg;
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	// read answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `CMICG_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_err ? `CMICG_RESP_SLVERR : `CMICG_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// [shared/cmicg_defs.vh]
// Purpose: constants for the can mode, interrupt and clock-gate wrapper
// Assumes: 32-bit axi4-lite register bus, word aligned registers
// Notes: offsets are byte addresses
`ifndef CMICG_DEFS_VH
`define CMICG_DEFS_VH

// register byte offsets
`define CMICG_OFS_CTRL      5'h00
`define CMICG_OFS_MODE_REQ  5'h04
`define CMICG_OFS_STATUS    5'h08
`define CMICG_OFS_GRP_FLAG  5'h0C
`define CMICG_OFS_GRP_CLR   5'h10
`define CMICG_OFS_SCI_FLAG  5'h14
`define CMICG_OFS_IRQ_STAT  5'h18
`define CMICG_OFS_IRQ_MASK  5'h1C

// controller modes
`define CMICG_MODE_W        2
`define CMICG_MODE_OPER     2'h0
`define CMICG_MODE_CONFIG   2'h1
`define CMICG_MODE_HALT     2'h2
`define CMICG_MODE_SLEEP    2'h3

// reset values
`define CMICG_CTRL_RST      1'h1
`define CMICG_MASK_RST      2'h0

// axi responses
`define CMICG_RESP_OKAY     2'h0
`define CMICG_RESP_SLVERR   2'h2

`endif

// [testbench/cmicg_can_model.sv]
// Purpose: behavioural can controller beside the wrapper
// Assumes: same clock as the wrapper
// Notes: a gated controller can neither raise requests nor accept modes
`timescale 1ns/1ps
module cmicg_can_model (
	input  wire       aclk,
	input  wire       can_clk_en,
	input  wire [3:0] src_cmd,
	input  wire       ack_cmd,
	output reg  [3:0] can_irq_src,
	output reg        can_mode_ack
);
	// outputs follow commands only while clocked
	always @(posedge aclk) begin
		can_irq_src  <= can_clk_en ? src_cmd : 4'h0;
		can_mode_ack <= can_clk_en & ack_cmd;
	end
endmodule

// [testbench/cmicg_monitor.sv]
// Purpose: port checker for the can mode, interrupt and clock-gate wrapper
// Assumes: one clock, synchronous active-low reset
// Notes: bound to cmicg_core
`timescale 1ns/1ps
module cmicg_monitor #(
	parameter N_SRC = 4
) (
	input wire             aclk,
	input wire             aresetn,
	input wire [N_SRC-1:0] can_irq_src,
	input wire             can_mode_ack,
	input wire [1:0]       can_mode,
	input wire             can_clk_en,
	input wire [N_SRC-1:0] group_edge_irq_req,
	input wire             soft_cfg_irq_b_req,
	input wire             dma_trigger,
	input wire             irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// first rise of source zero, then its group pulse
	sequence s_rise;
		$rose(can_irq_src[0]);
	endsequence
	sequence s_pulse;
		##[0:1] group_edge_irq_req[0];
	endsequence
	chk_no_dma: assert property (dma_trigger == 1'h0)
		else $error("dma trigger raised");
	chk_class_b_or: assert property (soft_cfg_irq_b_req == (|can_irq_src))
		else $error("class b request not the or of sources");
	chk_group_rise: assert property (s_rise |-> s_pulse)
		else $error("no group pulse after source rise");
	chk_group_pulse: assert property (group_edge_irq_req[0] |=> !group_edge_irq_req[0])
		else $error("group pulse longer than one cycle");
	chk_reset_state: assert property ($rose(aresetn) |-> !can_clk_en && can_mode == 2'h3)
		else $error("not sleeping and stopped after reset");
	chk_mode_cause: assert property (can_mode != $past(can_mode) |-> $past(can_mode_ack && can_clk_en))
		else $error("mode changed without accepted request");
	chk_stop_hold: assert property (!can_clk_en |=> $stable(can_mode))
		else $error("mode moved while clock gated");
	chk_irq_quiet: assert property ($rose(aresetn) |-> !irq)
		else $error("interrupt high after reset");
endmodule
bind cmicg_core cmicg_monitor #(.N_SRC(N_SRC)) u_mon (.aclk(aclk), .aresetn(aresetn),
	.can_irq_src(can_irq_src), .can_mode_ack(can_mode_ack), .can_mode(can_mode),
	.can_clk_en(can_clk_en), .group_edge_irq_req(group_edge_irq_req),
	.soft_cfg_irq_b_req(soft_cfg_irq_b_req), .dma_trigger(dma_trigger), .irq(irq));

// [testbench/tb.sv]
// Purpose: self-checking bench for cmicg_core
// Assumes: 200 MHz aclk, axi4-lite master tasks
// Notes: scenarios run in order and share interrupt state
`timescale 1ns/1ps
`include "cmicg_defs.vh"
module tb;
	reg aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, ack = 0;
	reg [4:0] aw = 0, ar = 0;
	reg [31:0] wd = 0, q;
	reg [3:0] src = 0;
	reg [3:0] ws = 4'hF;
	reg [1:0] r;
	wire [31:0] rd;
	wire [1:0] bresp, rresp, mode;
	wire [3:0] cs, grq;
	wire awr, wr_, arr, bv, rv, ma, cen, sb, dma, irq;
	integer err_count = 0, checks_done = 0;
	always #2.5 aclk = ~aclk;
	cmicg_can_model u_can (.aclk(aclk), .can_clk_en(cen), .src_cmd(src), .ack_cmd(ack),
		.can_irq_src(cs), .can_mode_ack(ma));
	cmicg_core #(.N_SRC(4)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
		.can_irq_src(cs), .can_mode_ack(ma), .can_mode(mode), .can_clk_en(cen),
		.group_edge_irq_req(grq), .soft_cfg_irq_b_req(sb), .dma_trigger(dma), .irq(irq));
	task ck(input string n, input [31:0] e, input [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// one bus transfer; handshakes judged on the level held before each edge
	task bus(input w, input [4:0] a, input [31:0] d);
		integer i;
		reg ta, tw, tr;
		begin
			@(posedge aclk);
			if (w) begin aw <= a; wd <= d; awv <= 1; wv <= 1; end
			else begin ar <= a; arv <= 1; end
			for (i = 0; i < 40; i++) begin
				@(negedge aclk);
				ta = awv & awr; tw = wv & wr_; tr = arv & arr;
				if (w ? bv : rv) begin q = rd; r = w ? bresp : rresp; i = 99; end
				@(posedge aclk);
				if (ta) awv <= 0;
				if (tw) wv <= 0;
				if (tr) arv <= 0;
			end
			if (i < 99) ck("bus answer", 1, 0);
		end
	endtask
	task t_reset;
		bus(0, `CMICG_OFS_CTRL, 0); ck("ctrl", 1, q);
		bus(0, `CMICG_OFS_STATUS, 0); ck("status", 3, q);
		bus(0, `CMICG_OFS_IRQ_MASK, 0); ck("mask", 0, q);
		bus(0, 5'h02, 0); ck("unaligned resp", 2, r);
		bus(1, 5'h06, 0); ck("unaligned write resp", 2, r);
		ws <= 4'h0;
		bus(1, `CMICG_OFS_IRQ_MASK, 3); ck("write resp", 0, r);
		ws <= 4'hF;
		bus(0, `CMICG_OFS_IRQ_MASK, 0); ck("strobe off mask", 0, q);
		$display("reset test done");
	endtask
	task t_mode;
		ack <= 1;
		bus(1, `CMICG_OFS_MODE_REQ, 1);
		bus(0, `CMICG_OFS_STATUS, 0); ck("stopped mode", 3, q);
		ck("clk gated", 0, cen);
		ack <= 0;
		bus(1, `CMICG_OFS_CTRL, 0); ck("clk running", 1, cen);
		bus(1, `CMICG_OFS_MODE_REQ, 1);
		bus(0, `CMICG_OFS_STATUS, 0); ck("no ack mode", 3, q);
		ack <= 1;
		repeat (3) @(posedge aclk);
		ack <= 0;
		bus(0, `CMICG_OFS_STATUS, 0); ck("config mode", 1, q);
		ck("mode pin", 1, mode);
		$display("mode test done");
	endtask
	task t_irq;
		bus(0, `CMICG_OFS_IRQ_STAT, 0); ck("stat mode", 2, q);
		src <= 4'h2;
		repeat (2) @(posedge aclk);
		bus(0, `CMICG_OFS_GRP_FLAG, 0); ck("group flag", 2, q);
		bus(1, `CMICG_OFS_GRP_CLR, 2);
		bus(0, `CMICG_OFS_GRP_FLAG, 0); ck("group clear", 0, q);
		ck("masked irq", 0, irq);
		bus(1, `CMICG_OFS_IRQ_MASK, 1); ck("irq", 1, irq);
		bus(0, `CMICG_OFS_IRQ_STAT, 0); ck("stat edge", 1, q);
		ck("irq cleared", 0, irq);
		src <= 4'h0;
		bus(0, `CMICG_OFS_SCI_FLAG, 0); ck("class b kept", 2, q);
		src <= 4'h1;
		repeat (2) @(posedge aclk);
		bus(0, `CMICG_OFS_SCI_FLAG, 0); ck("class b again", 3, q);
		ck("class b req", 1, sb);
		ck("irq on new edge", 1, irq);
		ck("dma", 0, dma);
		$display("interrupt test done");
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#40000;
		err_count++;
		results;
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_mode;
		t_irq;
		results;
	end
endmodule
